//--- hw/sacc_defines.svh
// Constants for the simultaneous conversion control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH
`define SACC_ADDR_SPAN0 6'h03
`define SACC_ADDR_SPAN1 6'h04
`define SACC_ADDR_SPAN2 6'h05
`define SACC_ADDR_SPAN3 6'h06
`define SACC_SPAN_10V 2'h0
`define SACC_SPAN_5V 2'h1
`define SACC_SPAN_2V5 2'h2
`define SACC_SW_MODE_PATTERN 3'h7
`define SACC_CLK_MHZ 50
`define SACC_CONV_TIME_NS 2000
`define SACC_CONV_CYCLES ((`SACC_CONV_TIME_NS * `SACC_CLK_MHZ) / 1000)
`define SACC_EXT_CLK_EDGES 16
`define SACC_SPAN_RESET 8'h00
`endif

//--- hw/sacc_pkg.sv
// Types shared by the conversion control block.
// Assumes sacc_defines.svh is on the include path.
`include "sacc_defines.svh"
package sacc_pkg;
    typedef logic [1:0] sacc_span_t;
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [5:0] addr;
        logic [7:0] wdata;
    } sacc_reg_req_t;
    typedef struct packed {
        logic [2:0] chan;
        logic [15:0] code;
        logic [1:0] span;
    } sacc_result_t;
endpackage

//--- hw/sacc_fifo.sv
// Result FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sacc_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // Handshakes; full and empty come straight from the count
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rp_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count next values
    always_comb begin
        wp_next = push ? AW'(wp_reg + 1'b1) : wp_reg;
        rp_next = pop ? AW'(rp_reg + 1'b1) : rp_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = (AW+1)'(cnt_reg + 1'b1);
        end else if (pop && !push) begin
            cnt_next = (AW+1)'(cnt_reg - 1'b1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; contents are only read when counted valid
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wp_reg] <= in_data;
        end
    end
endmodule

//--- hw/sacc_top.sv
// Conversion control for an eight-channel simultaneous-sampling converter.
// Assumes a 50 MHz sys_clk, synchronous rst, and pins already synchronous.
// Summary of operation
// - Hardware mode: range pin high gives +-10 V, low gives +-5 V, all channels.
// - Software mode: per-channel span from registers at 0x03 to 0x06.
// - Software mode ignores the range pin completely.
// - Software mode offers +-10, +-5 and +-2.5 V; hardware never +-2.5 V.
// - Start strobe rising edge samples all eight channels together.
// - Busy rises with the strobe, falls after all eight channels convert.
// - Strobe edges while busy are ignored, except as the external conversion clock.
// - Acquisition for the next conversion starts when busy falls.
// - New results readable after busy falls; host reads only then.
// - Previous results stay readable while converting; new ones load before busy falls.
// - Default timing comes from the internal oscillator within conversion time.
// - Software mode only: external conversion clock on the start strobe pin.
// - All eight channels always convert; unused ones are read out too.
// - Results are 16-bit two's complement codes.
// - Code step is span over 65536; transitions at half steps.
// - Reference pin high enables internal reference; low needs external 2.5 V.
// - Reference mode follows the reference pin as seen on leaving reset.
// - Oversampling pins all high select software mode, else hardware mode.
`timescale 1ns/1ps
`include "sacc_defines.svh"
module sacc_top #(
    parameter int CONV_CYCLES = `SACC_CONV_CYCLES,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic conversion_start_strobe,
    input wire logic [2:0] oversampling_select_pins,
    input wire logic range_select_pin,
    input wire logic ref_select_pin,
    input wire logic ext_clk_enable,
    input wire logic [8*16-1:0] analog_codes,
    input wire sacc_pkg::sacc_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic busy,
    output logic internal_ref_enable,
    output logic software_mode,
    output logic [15:0] gain_select,
    output logic [15:0] result_code [8],
    output sacc_pkg::sacc_result_t stream_data,
    output logic stream_valid,
    input wire logic stream_ready
);
    import sacc_pkg::*;

    typedef enum {ST_IDLE, ST_CONV, ST_PUSH} sacc_state_t;

    sacc_state_t state_reg, state_next;
    logic [7:0] span_reg [4];
    logic [7:0] span_next [4];
    logic strobe_d_reg;
    logic [15:0] sample_reg [8];
    logic [15:0] sample_next [8];
    logic [15:0] result_reg [8];
    logic [15:0] result_next [8];
    logic [15:0] gain_conv_reg, gain_conv_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [2:0] push_ch_reg, push_ch_next;
    logic ref_reg, ref_next, ref_caught_reg;
    logic strobe_rise, sw_mode, fifo_in_ready;
    logic [15:0] live_gain;
    sacc_result_t fifo_in;

    // Span field of one channel: two bits per channel, four channels per pair of registers
    function automatic sacc_span_t span_of(input logic [7:0] regs [4], input int ch);
        logic [7:0] r;
        r = regs[ch / 2];
        return (ch % 2 == 0) ? r[1:0] : r[5:4];
    endfunction

    // Mode decode from the oversampling pins
    assign sw_mode = (oversampling_select_pins == `SACC_SW_MODE_PATTERN);
    assign strobe_rise = conversion_start_strobe && !strobe_d_reg;

    // Live gain per channel; in hardware mode only the range pin counts
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            if (sw_mode) begin
                live_gain[2*c +: 2] = span_of(span_reg, c);
                if (span_of(span_reg, c) == 2'h3) begin
                    live_gain[2*c +: 2] = `SACC_SPAN_10V;
                end
            end else begin
                live_gain[2*c +: 2] = range_select_pin ? `SACC_SPAN_10V : `SACC_SPAN_5V;
            end
        end
    end

    // Span registers, written through the documented register port
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            span_next[i] = span_reg[i];
        end
        if (reg_req.wr_en) begin
            case (reg_req.addr)
                `SACC_ADDR_SPAN0: span_next[0] = reg_req.wdata;
                `SACC_ADDR_SPAN1: span_next[1] = reg_req.wdata;
                `SACC_ADDR_SPAN2: span_next[2] = reg_req.wdata;
                `SACC_ADDR_SPAN3: span_next[3] = reg_req.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                span_reg[i] <= `SACC_SPAN_RESET;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                span_reg[i] <= span_next[i];
            end
        end
    end

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd_en) begin
            case (reg_req.addr)
                `SACC_ADDR_SPAN0: reg_rdata <= span_reg[0];
                `SACC_ADDR_SPAN1: reg_rdata <= span_reg[1];
                `SACC_ADDR_SPAN2: reg_rdata <= span_reg[2];
                `SACC_ADDR_SPAN3: reg_rdata <= span_reg[3];
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Reference mode caught once, on the first clock after reset release
    always_comb begin
        ref_next = ref_caught_reg ? ref_reg : ref_select_pin;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_reg <= 1'b0;
            ref_caught_reg <= 1'b0;
        end else begin
            ref_reg <= ref_next;
            ref_caught_reg <= 1'b1;
        end
    end

    // Conversion sequencer. With the external clock option each strobe edge
    // during a conversion advances it, so the host must keep clocking.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        push_ch_next = push_ch_reg;
        gain_conv_next = gain_conv_reg;
        for (int c = 0; c < 8; c++) begin
            sample_next[c] = sample_reg[c];
            result_next[c] = result_reg[c];
        end
        case (state_reg)
            ST_IDLE: begin
                if (strobe_rise) begin
                    for (int c = 0; c < 8; c++) begin
                        sample_next[c] = analog_codes[16*c +: 16];
                    end
                    gain_conv_next = live_gain;
                    cnt_next = '0;
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                // Further strobe edges never restart here
                if (sw_mode && ext_clk_enable) begin
                    if (strobe_rise) begin
                        cnt_next = 16'(cnt_reg + 1'b1);
                    end
                    if (cnt_reg == 16'(`SACC_EXT_CLK_EDGES - 1) && strobe_rise) begin
                        state_next = ST_PUSH;
                    end
                end else begin
                    cnt_next = 16'(cnt_reg + 1'b1);
                    if (cnt_reg == 16'(CONV_CYCLES - 1)) begin
                        state_next = ST_PUSH;
                    end
                end
                if (state_next == ST_PUSH) begin
                    for (int c = 0; c < 8; c++) begin
                        result_next[c] = sample_reg[c];
                    end
                    push_ch_next = '0;
                end
            end
            ST_PUSH: begin
                // Busy stays high until every channel has entered the FIFO
                if (fifo_in_ready) begin
                    push_ch_next = 3'(push_ch_reg + 1'b1);
                    if (push_ch_reg == 3'h7) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            push_ch_reg <= '0;
            gain_conv_reg <= '0;
            strobe_d_reg <= 1'b0;
            for (int c = 0; c < 8; c++) begin
                sample_reg[c] <= 16'h0000;
                result_reg[c] <= 16'h0000;
            end
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            push_ch_reg <= push_ch_next;
            gain_conv_reg <= gain_conv_next;
            strobe_d_reg <= conversion_start_strobe;
            for (int c = 0; c < 8; c++) begin
                sample_reg[c] <= sample_next[c];
                result_reg[c] <= result_next[c];
            end
        end
    end

    // Outputs
    assign busy = (state_reg != ST_IDLE);
    assign internal_ref_enable = ref_reg;
    assign software_mode = sw_mode;
    assign gain_select = gain_conv_reg;
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            result_code[c] = result_reg[c];
        end
    end
    assign fifo_in.chan = push_ch_reg;
    assign fifo_in.code = result_reg[push_ch_reg];
    assign fifo_in.span = gain_conv_reg[2*push_ch_reg +: 2];

    sacc_fifo #(
        .WIDTH($bits(sacc_result_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_data(fifo_in),
        .in_valid(state_reg == ST_PUSH),
        .in_ready(fifo_in_ready),
        .out_data(stream_data),
        .out_valid(stream_valid),
        .out_ready(stream_ready)
    );

    // Busy goes high the cycle after an accepted strobe edge
    property p_busy_rise;
        @(posedge sys_clk) disable iff (rst)
        (!busy && strobe_rise) |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");

    property p_ignore_busy;
        @(posedge sys_clk) disable iff (rst)
        (busy && strobe_rise && !(sw_mode && ext_clk_enable)) |=> $stable(sample_reg[0]);
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) else $error("strobe while busy took sample");

    property p_hw_range;
        @(posedge sys_clk) disable iff (rst)
        (!busy && strobe_rise && !sw_mode) |=>
            gain_select[1:0] == ($past(range_select_pin) ? `SACC_SPAN_10V : `SACC_SPAN_5V);
    endproperty
    a_hw_range: assert property (p_hw_range) else $error("hardware span wrong");

    property p_no_2v5_hw;
        @(posedge sys_clk) disable iff (rst)
        !sw_mode |-> live_gain[15:14] != `SACC_SPAN_2V5;
    endproperty
    a_no_2v5_hw: assert property (p_no_2v5_hw) else $error("2.5 V span in hardware mode");

    property p_results_hold;
        @(posedge sys_clk) disable iff (rst)
        (busy && state_reg == ST_CONV && state_next == ST_CONV) |=> $stable(result_code[3]);
    endproperty
    a_results_hold: assert property (p_results_hold) else $error("old result lost");

    property p_sw_mode;
        @(posedge sys_clk) disable iff (rst)
        software_mode == (oversampling_select_pins == `SACC_SW_MODE_PATTERN);
    endproperty
    a_sw_mode: assert property (p_sw_mode) else $error("mode decode wrong");

    property p_conv_len;
        @(posedge sys_clk) disable iff (rst)
        (!busy && strobe_rise && !(sw_mode && ext_clk_enable)) |=> busy [*8];
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion ended early");

    property p_ref_hold;
        @(posedge sys_clk) disable iff (rst)
        ref_caught_reg |=> $stable(internal_ref_enable);
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference mode changed");
endmodule

//--- testbench/sacc_host_model.sv
// Host controller model: drives the start strobe and reads the result stream.
// Assumes the device clock; all changes land 1 ns after a rising edge.
`timescale 1ns/1ps
module sacc_host_model (
    input wire logic sys_clk,
    input wire logic busy,
    input wire logic stall_en,
    output logic conversion_start_strobe,
    output logic stream_ready
);
    initial begin
        conversion_start_strobe = 1'b0;
        stream_ready = 1'b0;
    end

    // Reads only once busy is low; random stalls keep the FIFO full longer
    always @(posedge sys_clk) begin
        stream_ready <= #1 (busy === 1'b0) && (!stall_en || $urandom_range(1) == 1);
    end

    // One strobe pulse; also serves as one cycle of the external conversion clock
    task automatic pulse(input int hi_cycles, input int lo_cycles);
        @(posedge sys_clk);
        #1;
        conversion_start_strobe = 1'b1;
        repeat (hi_cycles) @(posedge sys_clk);
        #1;
        conversion_start_strobe = 1'b0;
        repeat (lo_cycles) @(posedge sys_clk);
        #1;
    endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the conversion control block.
// Assumes sacc_pkg and the design files are compiled first.
`timescale 1ns/1ps
`include "sacc_defines.svh"
module testbench;
    import sacc_pkg::*;
    localparam int CONV = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic conversion_start_strobe, stream_ready, busy, internal_ref_enable, software_mode;
    logic stream_valid, stall_en = 1'b1, ext_clk_enable = 1'b0;
    logic range_select_pin = 1'b1, ref_select_pin = 1'b1;
    logic [2:0] oversampling_select_pins = 3'h0;
    logic [127:0] analog_codes = '0;
    sacc_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic [15:0] gain_select;
    logic [15:0] result_code [8];
    sacc_result_t stream_data;
    int errors = 0;
    int tests_run = 0;
    sacc_result_t exp_q [$];
    logic [1:0] span_exp [8];
    logic [15:0] prev_codes [8] = '{default: 16'h0000};
    logic [7:0] regv;

    // Shortened conversion count keeps the run brief
    always #10 sys_clk = ~sys_clk;

    sacc_top #(.CONV_CYCLES(CONV), .FIFO_DEPTH(8)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .conversion_start_strobe(conversion_start_strobe),
        .oversampling_select_pins(oversampling_select_pins),
        .range_select_pin(range_select_pin), .ref_select_pin(ref_select_pin),
        .ext_clk_enable(ext_clk_enable), .analog_codes(analog_codes), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .busy(busy), .internal_ref_enable(internal_ref_enable),
        .software_mode(software_mode), .gain_select(gain_select),
        .result_code(result_code), .stream_data(stream_data),
        .stream_valid(stream_valid), .stream_ready(stream_ready));

    sacc_host_model i_host (.sys_clk(sys_clk), .busy(busy), .stall_en(stall_en),
        .conversion_start_strobe(conversion_start_strobe), .stream_ready(stream_ready));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_res(input sacc_result_t exp, input sacc_result_t got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED stream_data expected %h seen %h", exp, got);
        end
    endtask

    task automatic report_and_stop;
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One register access; read data is settled right after the taking edge
    task automatic reg_acc(input logic wr, input logic [5:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        #1;
        reg_req = '{wr, !wr, addr, data};
        @(posedge sys_clk);
        #1;
        reg_req = '0;
    endtask

    // Full conversion: strobe, busy span, held and fresh results, stream order
    task automatic convert(input bit ext);
        time t0;
        int n;
        logic [15:0] newc [8];
        for (int c = 0; c < 8; c++) begin
            newc[c] = (c == 0) ? 16'h8000 : (c == 7) ? 16'h7fff : 16'($urandom);
            analog_codes[16*c +: 16] = newc[c];
            exp_q.push_back('{3'(c), newc[c], span_exp[c]});
        end
        i_host.pulse(1, 0);
        @(posedge sys_clk);
        #1;
        t0 = $time;
        chk("busy_rise", 16'h0001, 16'(busy));
        analog_codes = {8{16'h5a5a}};
        for (int c = 0; c < 8; c++) chk("held_result", prev_codes[c], result_code[c]);
        if (ext) begin
            repeat (`SACC_EXT_CLK_EDGES) i_host.pulse(1, 1);
        end else begin
            i_host.pulse(2, 2);
            chk("busy_ignored_edge", 16'h0001, 16'(busy));
        end
        n = 0;
        while (busy !== 1'b0 && n < CONV + 60) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        n = int'(($time - t0) / 20);
        if (!ext) chk("busy_len", 16'h0001, 16'(n >= CONV && n <= CONV + 12));
        chk("busy_fall", 16'h0000, 16'(busy));
        for (int c = 0; c < 8; c++) begin
            chk("result", newc[c], result_code[c]);
            chk("gain", 16'(span_exp[c]), 16'(gain_select[2*c +: 2]));
            prev_codes[c] = newc[c];
        end
        n = 0;
        while (exp_q.size() != 0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        #1;
        chk("pending", 16'h0000, 16'(exp_q.size()));
        chk("stream_idle", 16'h0000, 16'(stream_valid));
    endtask

    // Scoreboard: each popped stream word against the oldest expectation
    always @(posedge sys_clk) begin
        if (!rst && stream_valid === 1'b1 && stream_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected_word", 16'h0000, 16'h0001);
            end else begin
                chk_res(exp_q.pop_front(), stream_data);
            end
        end
    end

    // Watchdog sized well above the expected run
    initial begin
        #(20 * 20000);
        errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        void'($urandom(76));
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        @(posedge sys_clk);
        #1;
        chk("ref_en", 16'h0001, 16'(internal_ref_enable));
        ref_select_pin = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("ref_en_held", 16'h0001, 16'(internal_ref_enable));
        chk("busy_idle", 16'h0000, 16'(busy));
        for (int p = 0; p < 8; p++) begin
            oversampling_select_pins = 3'(p);
            @(posedge sys_clk);
            #1;
            chk("sw_mode", 16'(p == 7), 16'(software_mode));
        end
        for (int a = 3; a < 8; a++) begin
            reg_acc(1'b0, 6'(a), 8'h00);
            chk("reg_reset", 16'h0000, 16'(reg_rdata));
        end
        reg_acc(1'b1, 6'h07, 8'hff);
        reg_acc(1'b0, 6'h07, 8'h00);
        chk("unmapped", 16'h0000, 16'(reg_rdata));
        // Hardware mode, both range pin levels, settling allowed after each toggle
        for (int r = 1; r >= 0; r--) begin
            oversampling_select_pins = 3'($urandom_range(6));
            range_select_pin = r[0];
            repeat (4000) @(posedge sys_clk);
            #1;
            foreach (span_exp[c]) span_exp[c] = r ? `SACC_SPAN_10V : `SACC_SPAN_5V;
            convert(1'b0);
        end
        // Software mode: per-channel spans from registers, range pin ignored
        oversampling_select_pins = 3'h7;
        for (int k = 0; k < 4; k++) begin
            span_exp[2*k] = 2'($urandom_range(2));
            span_exp[2*k+1] = 2'($urandom_range(2));
            regv = {2'h0, span_exp[2*k+1], 2'h0, span_exp[2*k]};
            reg_acc(1'b1, 6'(3 + k), regv);
            reg_acc(1'b0, 6'(3 + k), 8'h00);
            chk("span_reg", 16'(regv), 16'(reg_rdata));
        end
        span_exp[5] = `SACC_SPAN_2V5;
        reg_acc(1'b1, `SACC_ADDR_SPAN2, {2'h0, span_exp[5], 2'h0, span_exp[4]});
        // Unused span code 3 falls back to the widest span
        span_exp[7] = `SACC_SPAN_10V;
        reg_acc(1'b1, `SACC_ADDR_SPAN3, {2'h0, 2'h3, 2'h0, span_exp[6]});
        range_select_pin = ~range_select_pin;
        convert(1'b0);
        ext_clk_enable = 1'b1;
        convert(1'b1);
        ext_clk_enable = 1'b0;
        // Second reset with the reference pin low selects the external reference
        @(posedge sys_clk);
        #1;
        rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("ref_ext", 16'h0000, 16'(internal_ref_enable));
        report_and_stop();
    end
endmodule
